// [logic/lsb_exec.sv]
// Execution unit for data-transfer and bit instructions of an 8-bit core.
// Assumes a decoder presenting lsb_pkg::lsb_instr_s with instr_valid, and a
// data memory answering reads combinationally in the cycle of the request.
//
// Contract
// - Post-increment load reads at pointer, then adds one; 2 cycles.
// - Pre-decrement load subtracts one, then reads; 2 cycles, flags kept.
// - Offset load reads pointer plus offset, pointer kept; 2 cycles.
// - Absolute load copies addressed byte into register in 2 cycles.
// - Post-increment write stores at pointer, then adds one; 2 cycles.
// - Pre-decrement write subtracts one first, then stores; 2 cycles.
// - Offset write stores at pointer plus offset, pointer kept; 2 cycles.
// - Absolute write stores register at instruction address; 2 cycles.
// - Push stores register on stack in 2 cycles, flags kept.
// - Pop loads register from stack in 2 cycles, flags kept.
// - I/O bit set forces chosen bit to one, others kept; 2 cycles.
// - I/O bit clear forces chosen bit to zero, others kept; 2 cycles.
// - Rotate left through carry, updates Z C N V in one cycle.
// - Rotate right through carry, updates Z C N V in one cycle.
// - Copy register bit into transfer flag, only that flag; one cycle.
// - Copy transfer flag into register bit, flags kept; one cycle.
// - Dedicated flag set/clear touches only its own flag; one cycle.
// - Generic flag set/clear writes indexed status bit; one cycle.
// - Sleep takes three cycles and changes no flag.
// - Watchdog restart takes one cycle, pulses restart, flags kept.
module lsb_exec
  import lsb_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire lsb_pkg::lsb_instr_s instr,
  input  wire logic              instr_valid,
  output logic                   issue_ready,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic                   mem_rd,
  output logic                   mem_wr,
  output logic [7:0]             mem_wdata,
  input  wire logic [7:0]        mem_rdata,
  output logic                   wdog_restart,
  output logic                   sleep_req,
  output logic [7:0]             flags,
  input  wire logic [4:0]        dbg_reg_idx,
  output logic [7:0]             dbg_reg_data
);
  import lsb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State.
  logic [7:0]        regs_ff [32];
  logic [7:0]        flags_ff;
  logic [15:0]       sp_ff;
  lsb_instr_s        cur_ff;
  logic [1:0]        cyc_ff;
  logic              busy_ff;
  logic [ADDR_W-1:0] ea_ff;
  logic              wdog_ff;
  logic              sleep_ff;
  logic [7:0]        dbg_ff;

  logic [1:0]        nxt_cyc;
  logic [4:0]        ptr_lo;
  logic [15:0]       ptr_val;
  logic [15:0]       ptr_dec;
  logic [15:0]       ea;
  logic              last_cyc;
  logic [7:0]        rot_res;
  logic              rot_c;
  lsb_instr_s        ex;

  ////////////////////////////////////////////////////////////////////////////
  // Issue control: first cycle uses the incoming instruction, later cycles
  // replay the latched one so the decoder may move on after the first cycle.
  assign ex       = busy_ff ? cur_ff : instr;
  assign last_cyc = busy_ff ? (cyc_ff == LSB_CYC_ONE) : (nxt_cyc == LSB_CYC_ONE);

  always_comb begin
    unique case (instr.op)
      LSB_OP_LD_PTR, LSB_OP_LD_DISP, LSB_OP_LD_ABS,
      LSB_OP_ST_PTR, LSB_OP_ST_DISP, LSB_OP_ST_ABS,
      LSB_OP_PUSH, LSB_OP_POP,
      LSB_OP_IO_SET, LSB_OP_IO_CLR: nxt_cyc = LSB_CYC_MEM;
      LSB_OP_SLEEP: nxt_cyc = LSB_CYC_SLEEP;
      default:      nxt_cyc = LSB_CYC_ONE;
    endcase
  end

  // Ready drops while a multi-cycle instruction runs.
  assign issue_ready = !busy_ff;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      busy_ff <= 1'b0;
      cyc_ff  <= 2'h0;
      cur_ff  <= '0;
    end else if (!busy_ff) begin
      if (instr_valid && (nxt_cyc != LSB_CYC_ONE)) begin
        busy_ff <= 1'b1;
        cyc_ff  <= nxt_cyc - 2'h1;
        cur_ff  <= instr;
      end
    end else begin
      cyc_ff <= cyc_ff - 2'h1;
      if (cyc_ff == LSB_CYC_ONE) begin
        busy_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address generation from the pointer pair, the stack pointer or the absolute address.
  always_comb begin
    unique case (ex.ptr)
      LSB_PTR_Y: ptr_lo = LSB_Y_LO;
      LSB_PTR_Z: ptr_lo = LSB_Z_LO;
      default:   ptr_lo = LSB_X_LO;
    endcase
  end

  assign ptr_val = {regs_ff[ptr_lo + 5'h01], regs_ff[ptr_lo]};
  assign ptr_dec = ptr_val - 16'h0001;

  always_comb begin
    unique case (ex.op)
      LSB_OP_LD_PTR, LSB_OP_ST_PTR:
        ea = (ex.pmode == LSB_PM_PREDEC) ? ptr_dec : ptr_val;
      LSB_OP_LD_DISP, LSB_OP_ST_DISP:
        ea = ptr_val + {10'h000, ex.disp};
      LSB_OP_PUSH: ea = sp_ff;
      LSB_OP_POP:  ea = sp_ff + 16'h0001;
      default:     ea = ex.addr;
    endcase
  end

  // The address is captured in the first cycle; the access happens in the
  // second, so a pointer update in the same cycle cannot disturb it.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ea_ff <= '0;
    end else if (!busy_ff) begin
      ea_ff <= ea[ADDR_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory strobes; loads and stores strobe in the final cycle of a two-cycle access.
  logic is_ld;
  logic is_st;
  logic is_io;
  assign is_ld = busy_ff && (cur_ff.op inside {LSB_OP_LD_PTR, LSB_OP_LD_DISP,
                 LSB_OP_LD_ABS, LSB_OP_POP});
  assign is_st = busy_ff && (cur_ff.op inside {LSB_OP_ST_PTR, LSB_OP_ST_DISP,
                 LSB_OP_ST_ABS, LSB_OP_PUSH});
  assign is_io = cur_ff.op inside {LSB_OP_IO_SET, LSB_OP_IO_CLR};

  // I/O bit ops read in the first cycle and write in the second.
  assign mem_addr = busy_ff ? ea_ff : ea[ADDR_W-1:0];
  assign mem_rd   = is_ld || (!busy_ff && instr_valid &&
                    (instr.op inside {LSB_OP_IO_SET, LSB_OP_IO_CLR}));
  assign mem_wr   = is_st || (busy_ff && is_io);

  logic [7:0] io_byte_ff;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      io_byte_ff <= 8'h00;
    end else if (!busy_ff) begin
      io_byte_ff <= mem_rdata;
    end
  end

  always_comb begin
    mem_wdata = regs_ff[cur_ff.reg_idx];
    if (is_io) begin
      mem_wdata = io_byte_ff;
      mem_wdata[cur_ff.bit_idx] = (cur_ff.op == LSB_OP_IO_SET);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rotate datapath through carry.
  always_comb begin
    if (ex.op == LSB_OP_ROL) begin
      rot_res = {regs_ff[ex.reg_idx][6:0], flags_ff[LSB_FLAG_C]};
      rot_c   = regs_ff[ex.reg_idx][7];
    end else begin
      rot_res = {flags_ff[LSB_FLAG_C], regs_ff[ex.reg_idx][7:1]};
      rot_c   = regs_ff[ex.reg_idx][0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file writes: loads, pointer updates, rotates and bit loads.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < 32; i++) begin
        regs_ff[i] <= 8'h00;
      end
    end else begin
      // Pointer modify happens in the first cycle.
      if (!busy_ff && instr_valid &&
          (instr.op inside {LSB_OP_LD_PTR, LSB_OP_ST_PTR})) begin
        if (instr.pmode == LSB_PM_POSTINC) begin
          {regs_ff[ptr_lo + 5'h01], regs_ff[ptr_lo]} <= ptr_val + 16'h0001;
        end else if (instr.pmode == LSB_PM_PREDEC) begin
          {regs_ff[ptr_lo + 5'h01], regs_ff[ptr_lo]} <= ptr_dec;
        end
      end
      if (is_ld) begin
        regs_ff[cur_ff.reg_idx] <= mem_rdata;
      end
      if (!busy_ff && instr_valid) begin
        if (instr.op inside {LSB_OP_ROL, LSB_OP_ROR}) begin
          regs_ff[instr.reg_idx] <= rot_res;
        end else if (instr.op == LSB_OP_BLD) begin
          regs_ff[instr.reg_idx][instr.bit_idx] <= flags_ff[LSB_FLAG_T];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack pointer: post-decrement on push, pre-increment on pop.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sp_ff <= LSB_SP_RST;
    end else if (busy_ff && last_cyc) begin
      if (cur_ff.op == LSB_OP_PUSH) begin
        sp_ff <= sp_ff - 16'h0001;
      end else if (cur_ff.op == LSB_OP_POP) begin
        sp_ff <= sp_ff + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags. Only single-cycle ops touch them; all memory, stack,
  // sleep and watchdog ops leave them alone.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      flags_ff <= LSB_FLAGS_RST;
    end else if (!busy_ff && instr_valid) begin
      unique case (instr.op)
        LSB_OP_ROL, LSB_OP_ROR: begin
          flags_ff[LSB_FLAG_C] <= rot_c;
          flags_ff[LSB_FLAG_Z] <= (rot_res == 8'h00);
          flags_ff[LSB_FLAG_N] <= rot_res[7];
          flags_ff[LSB_FLAG_V] <= rot_res[7] ^ rot_c;
        end
        LSB_OP_BST: begin
          flags_ff[LSB_FLAG_T] <= regs_ff[instr.reg_idx][instr.bit_idx];
        end
        // Dedicated flag ops are decoded to these with a fixed index.
        LSB_OP_FLAG_SET: flags_ff[instr.bit_idx] <= 1'b1;
        LSB_OP_FLAG_CLR: flags_ff[instr.bit_idx] <= 1'b0;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Side-effect outputs, registered so they start one cycle after issue.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wdog_ff  <= 1'b0;
      sleep_ff <= 1'b0;
      dbg_ff   <= 8'h00;
    end else begin
      wdog_ff  <= !busy_ff && instr_valid && (instr.op == LSB_OP_WDR);
      sleep_ff <= !busy_ff && instr_valid && (instr.op == LSB_OP_SLEEP);
      dbg_ff   <= regs_ff[dbg_reg_idx];
    end
  end

  assign wdog_restart = wdog_ff;
  assign sleep_req    = sleep_ff;
  assign flags        = flags_ff;
  assign dbg_reg_data = dbg_ff;

endmodule

// [logic/lsb_pkg.sv]
// Package for the load/store and bit-operation execution block.
// Assumes one clock domain and a decoded instruction arriving from a fetch
// stage that honours the issue-ready handshake.
package lsb_pkg;

  // Operation codes delivered by the decoder.
  typedef enum logic [4:0] {
    LSB_OP_NOP      = 5'h00,
    LSB_OP_LD_PTR   = 5'h01,
    LSB_OP_LD_DISP  = 5'h02,
    LSB_OP_LD_ABS   = 5'h03,
    LSB_OP_ST_PTR   = 5'h04,
    LSB_OP_ST_DISP  = 5'h05,
    LSB_OP_ST_ABS   = 5'h06,
    LSB_OP_PUSH     = 5'h07,
    LSB_OP_POP      = 5'h08,
    LSB_OP_IO_SET   = 5'h09,
    LSB_OP_IO_CLR   = 5'h0a,
    LSB_OP_ROL      = 5'h0b,
    LSB_OP_ROR      = 5'h0c,
    LSB_OP_BST      = 5'h0d,
    LSB_OP_BLD      = 5'h0e,
    LSB_OP_FLAG_SET = 5'h0f,
    LSB_OP_FLAG_CLR = 5'h10,
    LSB_OP_SLEEP    = 5'h11,
    LSB_OP_WDR      = 5'h12
  } lsb_op_e;

  // Pointer addressing modes.
  typedef enum logic [1:0] {
    LSB_PM_PLAIN = 2'h0,
    LSB_PM_POSTINC = 2'h1,
    LSB_PM_PREDEC = 2'h2
  } lsb_pmode_e;

  // Which pointer pair is used.
  typedef enum logic [1:0] {
    LSB_PTR_X = 2'h0,
    LSB_PTR_Y = 2'h1,
    LSB_PTR_Z = 2'h2
  } lsb_ptr_e;

  // Decoded instruction carrier.
  typedef struct packed {
    lsb_op_e    op;
    lsb_ptr_e   ptr;
    lsb_pmode_e pmode;
    logic [4:0] reg_idx;
    logic [2:0] bit_idx;
    logic [5:0] disp;
    logic [15:0] addr;
  } lsb_instr_s;

  // Status register bit positions.
  localparam int LSB_FLAG_C = 0;
  localparam int LSB_FLAG_Z = 1;
  localparam int LSB_FLAG_N = 2;
  localparam int LSB_FLAG_V = 3;
  localparam int LSB_FLAG_S = 4;
  localparam int LSB_FLAG_H = 5;
  localparam int LSB_FLAG_T = 6;
  localparam int LSB_FLAG_I = 7;

  // Register file locations of the pointer pairs (low byte).
  localparam logic [4:0] LSB_X_LO = 5'h1a;
  localparam logic [4:0] LSB_Y_LO = 5'h1c;
  localparam logic [4:0] LSB_Z_LO = 5'h1e;

  // Reset values.
  localparam logic [7:0]  LSB_FLAGS_RST = 8'h00;
  localparam logic [15:0] LSB_SP_RST    = 16'h00df;

  // Cycle counts per class.
  localparam logic [1:0] LSB_CYC_MEM   = 2'h2;
  localparam logic [1:0] LSB_CYC_SLEEP = 2'h3;
  localparam logic [1:0] LSB_CYC_ONE   = 2'h1;

endpackage

// [test/lsb_mem_model.sv]
// Behavioural data memory and I/O space facing the execution unit.
// Assumes reads are answered in the cycle of mem_rd and writes land at edge.
module lsb_mem_model (
  input  wire logic        core_clk,
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];

  // Outside a read the bus shows the inverted byte, so a stale capture fails.
  assign mem_rdata = mem_rd ? mem[mem_addr[7:0]] : ~mem[mem_addr[7:0]];

  // A write takes effect at the edge that closes its cycle.
  always @(posedge core_clk) begin
    if (mem_wr) begin
      mem[mem_addr[7:0]] <= mem_wdata;
    end
  end
endmodule

// [test/lsb_exec_chk.sv]
// Timing and side-effect checker for the load/store and bit unit.
// Assumes it sees only the ports of lsb_exec and is attached by bind.
module lsb_exec_chk
  import lsb_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic                core_clk,
  input wire logic                srst,
  input wire lsb_pkg::lsb_instr_s instr,
  input wire logic                instr_valid,
  input wire logic                issue_ready,
  input wire logic [ADDR_W-1:0]   mem_addr,
  input wire logic                mem_rd,
  input wire logic                mem_wr,
  input wire logic [7:0]          mem_wdata,
  input wire logic [7:0]          mem_rdata,
  input wire logic                wdog_restart,
  input wire logic                sleep_req,
  input wire logic [7:0]          flags,
  input wire logic [4:0]          dbg_reg_idx,
  input wire logic [7:0]          dbg_reg_data
);
  timeunit 1ns;
  timeprecision 1ps;
  wire take;
  // An instruction counts only at an edge where the unit is ready.
  assign take = instr_valid && issue_ready;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////
  a_load_two_cyc: assert property (take && instr.op inside {LSB_OP_LD_PTR,
    LSB_OP_LD_DISP, LSB_OP_LD_ABS, LSB_OP_POP} |=> mem_rd && !mem_wr
    && !issue_ready ##1 issue_ready) else $error("load timing wrong");
  a_store_two_cyc: assert property (take && instr.op inside {LSB_OP_ST_PTR,
    LSB_OP_ST_DISP, LSB_OP_ST_ABS, LSB_OP_PUSH} |=> mem_wr && !mem_rd
    && !issue_ready ##1 issue_ready) else $error("store timing wrong");
  a_abs_addr_used: assert property (take && instr.op inside {LSB_OP_LD_ABS,
    LSB_OP_ST_ABS} |=> mem_addr == $past(instr.addr))
    else $error("absolute address not used");
  a_io_bit_set: assert property (take && instr.op == LSB_OP_IO_SET |->
    mem_rd ##1 mem_wr && mem_addr == $past(mem_addr) && mem_wdata ==
    ($past(mem_rdata) | (8'h01 << $past(instr.bit_idx))))
    else $error("io bit set wrong");
  a_io_bit_clear: assert property (take && instr.op == LSB_OP_IO_CLR |->
    mem_rd ##1 mem_wr && mem_wdata ==
    ($past(mem_rdata) & ~(8'h01 << $past(instr.bit_idx))))
    else $error("io bit clear wrong");
  a_flags_kept_mem: assert property (take && instr.op inside {[LSB_OP_LD_PTR:
    LSB_OP_IO_CLR], LSB_OP_SLEEP} |=> $stable(flags) [*2])
    else $error("memory op changed flags");
  a_flag_set_bit: assert property (take && instr.op == LSB_OP_FLAG_SET |=>
    flags == ($past(flags) | (8'h01 << $past(instr.bit_idx))))
    else $error("flag set wrong");
  a_sleep_three: assert property (take && instr.op == LSB_OP_SLEEP |=>
    sleep_req && !issue_ready ##1 !issue_ready && !sleep_req ##1 issue_ready)
    else $error("sleep timing wrong");
  a_wdog_pulse: assert property (take && instr.op == LSB_OP_WDR |=>
    wdog_restart && $stable(flags) ##1 !wdog_restart)
    else $error("watchdog restart wrong");
  c_load_ptr: cover property (take && instr.op == LSB_OP_LD_PTR);
  c_io_set: cover property (take && instr.op == LSB_OP_IO_SET);
  c_sleep: cover property (take && instr.op == LSB_OP_SLEEP);
endmodule

bind lsb_exec lsb_exec_chk #(.ADDR_W(ADDR_W)) lsb_exec_chk_i (.core_clk,
  .srst, .instr, .instr_valid, .issue_ready, .mem_addr, .mem_rd, .mem_wr,
  .mem_wdata, .mem_rdata, .wdog_restart, .sleep_req, .flags, .dbg_reg_idx,
  .dbg_reg_data);

// [test/load_store_bit_ops_exec_bench.sv]
// Self-checking bench for the load/store and bit-operation unit.
// Assumes lsb_exec, the memory model and the bound checker are compiled.
module load_store_bit_ops_exec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import lsb_pkg::*;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  lsb_instr_s  instr = '0;
  logic        instr_valid = 1'b0;
  logic [4:0]  dbg_reg_idx = 5'h00;
  logic        issue_ready, mem_rd, mem_wr, wdog_restart, sleep_req;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata, mem_rdata, flags, dbg_reg_data, fl;
  int          err_count = 0;
  int          compares = 0;
  int          cyc = 0;

  lsb_exec lsb_exec_i (.core_clk, .srst, .instr, .instr_valid, .issue_ready,
    .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .wdog_restart,
    .sleep_req, .flags, .dbg_reg_idx, .dbg_reg_data);
  lsb_mem_model lsb_mem_model_i (.core_clk, .mem_addr, .mem_rd, .mem_wr,
    .mem_wdata, .mem_rdata);

  // Free-running 25 MHz clock.
  always #20 core_clk = ~core_clk;

  // Cycle ceiling well above the roughly 130 cycles the tests need.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, got);
    compares++;
    if (exp !== got) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Issues one instruction, then times the busy window and checks flags.
  task automatic ex(input lsb_op_e op, input lsb_pmode_e pm,
                    input logic [4:0] r, input logic [2:0] b,
                    input logic [5:0] d, input logic [15:0] a, input int nc);
    logic [15:0] n;
    @(posedge core_clk);
    instr <= '{op, LSB_PTR_Z, pm, r, b, d, a};
    instr_valid <= 1'b1;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    #1;
    n = 16'h0001;
    while (issue_ready !== 1'b1 && n < 16'h0008) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("cycles", 16'(nc), n);
    chk("flags", {8'h00, fl}, {8'h00, flags});
  endtask

  // The register peek answers one cycle after the index is given.
  task automatic rg(input logic [4:0] i, input logic [7:0] exp);
    @(posedge core_clk);
    dbg_reg_idx <= i;
    @(posedge core_clk);
    #1;
    chk($sformatf("r%0d", i), {8'h00, exp}, {8'h00, dbg_reg_data});
  endtask

  task automatic mm(input logic [7:0] a, input logic [7:0] exp);
    chk($sformatf("mem %h", a), {8'h00, exp}, {8'h00, lsb_mem_model_i.mem[a]});
  endtask

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: the memory is cleared, then seeded with known bytes.
  initial begin
    fl = 8'h00;
    for (int i = 0; i < 256; i++) begin
      lsb_mem_model_i.mem[i] = 8'h00;
    end
    lsb_mem_model_i.mem[8'h10] = 8'ha5;
    lsb_mem_model_i.mem[8'h11] = 8'h20;
    lsb_mem_model_i.mem[8'h20] = 8'h3c;
    lsb_mem_model_i.mem[8'h25] = 8'h77;
    lsb_mem_model_i.mem[8'h40] = 8'h81;
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    ex(LSB_OP_LD_ABS, LSB_PM_PLAIN, 5'h01, 3'h0, 6'h00, 16'h0010, 2);
    rg(5'h01, 8'ha5);
    ex(LSB_OP_LD_ABS, LSB_PM_PLAIN, LSB_Z_LO, 3'h0, 6'h00, 16'h0011, 2);
    ex(LSB_OP_LD_PTR, LSB_PM_POSTINC, 5'h02, 3'h0, 6'h00, 16'h0000, 2);
    rg(5'h02, 8'h3c);
    rg(LSB_Z_LO, 8'h21);
    ex(LSB_OP_LD_PTR, LSB_PM_PREDEC, 5'h03, 3'h0, 6'h00, 16'h0000, 2);
    rg(5'h03, 8'h3c);
    rg(LSB_Z_LO, 8'h20);
    ex(LSB_OP_LD_DISP, LSB_PM_PLAIN, 5'h04, 3'h0, 6'h05, 16'h0000, 2);
    rg(5'h04, 8'h77);
    rg(LSB_Z_LO, 8'h20);
    $display("test loads done");
    ex(LSB_OP_ST_ABS, LSB_PM_PLAIN, 5'h01, 3'h0, 6'h00, 16'h0030, 2);
    mm(8'h30, 8'ha5);
    ex(LSB_OP_ST_PTR, LSB_PM_POSTINC, 5'h04, 3'h0, 6'h00, 16'h0000, 2);
    mm(8'h20, 8'h77);
    rg(LSB_Z_LO, 8'h21);
    ex(LSB_OP_ST_PTR, LSB_PM_PREDEC, 5'h01, 3'h0, 6'h00, 16'h0000, 2);
    mm(8'h20, 8'ha5);
    rg(LSB_Z_LO, 8'h20);
    ex(LSB_OP_ST_DISP, LSB_PM_PLAIN, 5'h02, 3'h0, 6'h06, 16'h0000, 2);
    mm(8'h26, 8'h3c);
    ex(LSB_OP_PUSH, LSB_PM_PLAIN, 5'h04, 3'h0, 6'h00, 16'h0000, 2);
    mm(8'hdf, 8'h77);
    ex(LSB_OP_POP, LSB_PM_PLAIN, 5'h05, 3'h0, 6'h00, 16'h0000, 2);
    rg(5'h05, 8'h77);
    ex(LSB_OP_IO_SET, LSB_PM_PLAIN, 5'h00, 3'h3, 6'h00, 16'h0040, 2);
    mm(8'h40, 8'h89);
    ex(LSB_OP_IO_CLR, LSB_PM_PLAIN, 5'h00, 3'h7, 6'h00, 16'h0040, 2);
    mm(8'h40, 8'h09);
    $display("test stores done");
    // Every flag is set in turn, then cleared, so each step keeps the rest.
    for (int i = 0; i < 8; i++) begin
      fl[i] = 1'b1;
      ex(LSB_OP_FLAG_SET, LSB_PM_PLAIN, 5'h00, 3'(i), 6'h00, 16'h0000, 1);
    end
    for (int i = 0; i < 8; i++) begin
      fl[i] = 1'b0;
      ex(LSB_OP_FLAG_CLR, LSB_PM_PLAIN, 5'h00, 3'(i), 6'h00, 16'h0000, 1);
    end
    fl = 8'h01;
    ex(LSB_OP_FLAG_SET, LSB_PM_PLAIN, 5'h00, 3'h0, 6'h00, 16'h0000, 1);
    fl = 8'h09;
    ex(LSB_OP_ROL, LSB_PM_PLAIN, 5'h01, 3'h0, 6'h00, 16'h0000, 1);
    rg(5'h01, 8'h4b);
    fl = 8'h05;
    ex(LSB_OP_ROR, LSB_PM_PLAIN, 5'h01, 3'h0, 6'h00, 16'h0000, 1);
    rg(5'h01, 8'ha5);
    fl = 8'h45;
    ex(LSB_OP_BST, LSB_PM_PLAIN, 5'h01, 3'h0, 6'h00, 16'h0000, 1);
    ex(LSB_OP_BLD, LSB_PM_PLAIN, 5'h04, 3'h3, 6'h00, 16'h0000, 1);
    rg(5'h04, 8'h7f);
    ex(LSB_OP_SLEEP, LSB_PM_PLAIN, 5'h00, 3'h0, 6'h00, 16'h0000, 3);
    ex(LSB_OP_WDR, LSB_PM_PLAIN, 5'h00, 3'h0, 6'h00, 16'h0000, 1);
    $display("test bits done");
    end_of_test();
  end
endmodule
